/* File: src/stcd_cfg.svh */
// Constants for the command-descriptor-block decoder.
`ifndef STCD_CFG_SVH
`define STCD_CFG_SVH
`define STCD_OP_CHGDEF 8'h40
`define STCD_OP_FORMAT 8'h04
`define STCD_OP_INQUIRY 8'h12
`define STCD_OP_MSEL6 8'h15
`define STCD_OP_MSEL10 8'h55
`define STCD_OP_MSNS6 8'h1A
`define STCD_OP_MSNS10 8'h5A
`define STCD_OP_READ6 8'h08
`define STCD_OP_READ10 8'h28
`define STCD_OP_RDBUF 8'h3C
`define STCD_CTL_LINK 0
`define STCD_CTL_FLAG 1
`define STCD_CTL_WP 7
`define STCD_LUN_OK 3'h0
`define STCD_INQ_LEN 8'h24
`define STCD_BLK_DEFAULT 16'h0200
`define STCD_INTERLEAVE 8'h01
`define STCD_REG_CTRL 12'h000
`define STCD_REG_STATUS 12'h004
`define STCD_REG_RESULT 12'h008
`define STCD_REG_CDB0 12'h010
`define STCD_REG_CDB1 12'h014
`define STCD_REG_CDB2 12'h018
`define STCD_REG_MODE 12'h01C
`define STCD_REG_PARAM 12'h020
`define STCD_CTRL_RESET 32'h0000_0000
`define STCD_SNS_NONE 4'h0
`define STCD_SNS_OPCODE 4'h1
`define STCD_SNS_LUN 4'h2
`define STCD_SNS_FIELD 4'h3
`define STCD_SNS_NOTREADY 4'h4
`define STCD_SNS_WPROT 4'h5
`endif

/* File: src/stcd_pkg.sv */
// Types shared by the command-descriptor-block decoder.
`default_nettype none
package stcd_pkg;
  typedef enum logic [2:0] {
    STCD_ST_GOOD = 3'h0,
    STCD_ST_CHECK = 3'h1,
    STCD_ST_INTER = 3'h2
  } stcd_status_t;
  typedef enum logic [1:0] {
    STCD_MSG_COMPLETE = 2'h0,
    STCD_MSG_LINKED = 2'h1,
    STCD_MSG_LINKED_FLAG = 2'h2
  } stcd_msg_t;
  typedef enum logic [2:0] {
    STCD_FSM_IDLE = 3'b001,
    STCD_FSM_CHECK = 3'b010,
    STCD_FSM_DONE = 3'b100
  } stcd_fsm_t;
endpackage
`default_nettype wire

/* File: src/stcd_cmd_if.sv */
// Interface carrying a decode request and its result between decoder modules.
`default_nettype none
interface stcd_cmd_if;
  logic [127:0] cdb;
  logic spun_up;
  logic wprot;
  logic [7:0] opcode;
  logic known;
  logic lun_bad;
  logic field_bad;
  logic not_ready;
  logic wp_block;
  logic link;
  logic flag;
  logic wp_bit;
  logic is_msel;
  logic is_chgdef;
  logic [1:0] page_ctl;
  logic [5:0] page_code;
  modport dec (input cdb, spun_up, wprot, output opcode, known, lun_bad, field_bad, not_ready,
    wp_block, link, flag, wp_bit, is_msel, is_chgdef, page_ctl, page_code);
  modport ctl (output cdb, spun_up, wprot, input opcode, known, lun_bad, field_bad, not_ready,
    wp_block, link, flag, wp_bit, is_msel, is_chgdef, page_ctl, page_code);
endinterface
`default_nettype wire

/* File: src/stcd_decode.sv */
// Combinational field checks for one command descriptor block.
`include "stcd_cfg.svh"
`default_nettype none
module stcd_decode
  import stcd_pkg::*;
(
  stcd_cmd_if.dec c
);
  function automatic logic [7:0] cb(input logic [127:0] v, input int i);
    cb = v[i*8 +: 8];
  endfunction
  function automatic logic page_ok(input logic [5:0] p);
    page_ok = (p == 6'h01) || (p == 6'h02) || (p == 6'h03) || (p == 6'h04) ||
              (p == 6'h08) || (p == 6'h09) || (p == 6'h0A); // [RQ17]
  endfunction
  logic [7:0] op;
  logic [7:0] ctl;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [7:0] b3;
  logic ten;
  logic bad;
  always_comb begin
    op = cb(c.cdb, 0);
    b1 = cb(c.cdb, 1);
    b2 = cb(c.cdb, 2);
    b3 = cb(c.cdb, 3);
    // Command groups one and two carry ten-byte blocks, so their control byte is byte 9.
    ten = (op[7:5] == 3'h1) || (op[7:5] == 3'h2); // [RQ4]
    ctl = ten ? cb(c.cdb, 9) : cb(c.cdb, 5); // [RQ4]
    c.opcode = op;
    c.link = ctl[`STCD_CTL_LINK]; // [RQ4]
    c.flag = ctl[`STCD_CTL_FLAG]; // [RQ4]
    c.wp_bit = ctl[`STCD_CTL_WP];
    c.is_msel = (op == `STCD_OP_MSEL6) || (op == `STCD_OP_MSEL10);
    c.is_chgdef = (op == `STCD_OP_CHGDEF);
    c.page_ctl = b2[7:6]; // [RQ18]
    c.page_code = b2[5:0];
    c.known = 1'b1;
    bad = 1'b0;
    // Vendor and reserved control bits must be zero; bit 7 is write protect on mode select.
    if (ctl[5:2] != 4'h0 || (!c.is_msel && ctl[7:6] != 2'h0) || (c.is_msel && ctl[6])) begin
      bad = 1'b1; // [RQ3]
    end
    if (!c.link && c.flag) begin
      bad = 1'b1; // [RQ6]
    end
    c.not_ready = 1'b0;
    c.wp_block = 1'b0;
    if (op == `STCD_OP_INQUIRY) begin
      if (cb(c.cdb, 3) != 8'h00) begin
        bad = 1'b1; // [RQ3]
      end
    end else if (op == `STCD_OP_CHGDEF) begin
      c.not_ready = !c.spun_up; // [RQ10]
      c.wp_block = c.wprot; // [RQ10]
      if (b3[6:0] > 7'h04 || b1[4:0] != 5'h00) begin
        bad = 1'b1; // [RQ10]
      end
    end else if (op == `STCD_OP_FORMAT) begin
      c.not_ready = !c.spun_up; // [RQ12]
      c.wp_block = c.wprot; // [RQ12]
      // Defect list format: 100 bytes-from-index or 101 physical sector.
      if (b1[4] && b1[2:1] != 2'b10) begin
        bad = 1'b1; // [RQ13]
      end
    end else if (c.is_msel) begin
      c.not_ready = !c.spun_up && b1[0]; // [RQ16]
      if (b1[3:1] != 3'h0) begin
        bad = 1'b1; // [RQ3]
      end
    end else if (op == `STCD_OP_MSNS6 || op == `STCD_OP_MSNS10) begin
      c.not_ready = !c.spun_up && (c.page_ctl == 2'b11); // [RQ18]
      if (!page_ok(c.page_code) && c.page_code != 6'h3F) begin
        bad = 1'b1; // [RQ17]
      end
    end else if (op == `STCD_OP_READ6 || op == `STCD_OP_READ10) begin
      c.not_ready = !c.spun_up; // [RQ20]
      if (ten && (b1[0] || cb(c.cdb, 6) != 8'h00)) begin
        bad = 1'b1; // [RQ3]
      end
    end else if (op == `STCD_OP_RDBUF) begin
      c.not_ready = !c.spun_up;
    end else begin
      c.known = 1'b0; // [RQ23]
    end
    c.lun_bad = (op != `STCD_OP_INQUIRY) && (b1[7:5] != `STCD_LUN_OK); // [RQ1]
    c.field_bad = bad;
  end
endmodule
`default_nettype wire

/* File: src/stcd_top.sv */
// AXI4-Lite command-descriptor-block decoder for a disk target.
// Notes on behaviour
// RQ1: Commands use LUN 0; inquiry takes any.
// RQ2: Initiator zeroes every reserved field.
// RQ3: Check reserved and vendor fields; else invalid.
// RQ4: Last byte is control; link, flag bits.
// RQ5: Linked success gives intermediate, linked message.
// RQ6: Flag must be clear when link clear.
// RQ7: Link without flag sends linked complete.
// RQ8: Link with flag sends flagged linked complete.
// RQ9: Mode select bit 7 sets write protect.
// RQ10: Change definition; refused unspun or protected.
// RQ11: Format always uses interleave of one.
// RQ12: Format refused unspun or protected; defects accepted.
// RQ13: Data defect list: sector or index format.
// RQ14: Inquiry returns 36 bytes always.
// RQ15: Extra product pages may follow on request.
// RQ16: Mode select limits type, density, block length.
// RQ17: Only pages 01-04, 08, 09, 0A; mode sense also accepts page 3F.
// RQ18: Mode sense page control decoded two bits.
// RQ19: Default logical block size is 512.
// RQ20: Read six and ten byte; needs spin-up.
// RQ21: Initiator reserves unit before buffer tests.
// RQ22: Intermediate for every linked command but last.
// RQ23: Failures give check condition and sense.
`include "stcd_cfg.svh"
`default_nettype none
module stcd_top
  import stcd_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  if (ADDR_W < 6 || ADDR_W > 12) begin
    $error("ADDR_W out of range");
  end
  stcd_cmd_if c ();
  stcd_decode u_dec (
    .c(c)
  );
  logic [127:0] cdb_reg, cdb_next;
  logic spun_reg, spun_next;
  logic wp_reg, wp_next;
  logic def_reg, def_next;
  logic [15:0] blk_reg, blk_next;
  logic [7:0] xfer_reg, xfer_next;
  logic [7:0] ilv_reg, ilv_next;
  logic [1:0] pc_reg, pc_next;
  logic [5:0] pg_reg, pg_next;
  stcd_status_t st_reg, st_next;
  stcd_msg_t msg_reg, msg_next;
  logic [3:0] sns_reg, sns_next;
  logic chain_reg, chain_next;
  logic done_reg, done_next;
  logic vpd_reg, vpd_next;
  stcd_fsm_t fsm_reg, fsm_next;
  logic [ADDR_W-1:0] awa_reg, awa_next;
  logic aw_reg, aw_next;
  logic [31:0] wd_reg, wd_next;
  logic [3:0] ws_reg, ws_next;
  logic w_reg, w_next;
  logic bv_reg, bv_next;
  logic [1:0] br_reg, br_next;
  logic rv_reg, rv_next;
  logic [31:0] rd_reg, rd_next;
  logic [1:0] rr_reg, rr_next;
  logic [11:0] wa;
  logic [11:0] ra;
  logic wr_ok;
  logic go;
  assign c.cdb = cdb_reg;
  assign c.spun_up = spun_reg;
  assign c.wprot = wp_reg;
  assign s_axi_awready = !aw_reg && !bv_reg;
  assign s_axi_wready = !w_reg && !bv_reg;
  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp = br_reg;
  assign s_axi_arready = !rv_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rdata = rd_reg;
  assign s_axi_rresp = rr_reg;
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    merge = r;
  endfunction
  function automatic logic blk_ok(input logic [15:0] b);
    blk_ok = (b == 16'h0200) || (b == 16'h0400) || (b == 16'h0800) || (b == 16'h1000); // [RQ16]
  endfunction
  always_comb begin
    ra = 12'(s_axi_araddr);
    aw_next = aw_reg;
    awa_next = awa_reg;
    w_next = w_reg;
    wd_next = wd_reg;
    ws_next = ws_reg;
    bv_next = bv_reg;
    br_next = br_reg;
    rv_next = rv_reg;
    rd_next = rd_reg;
    rr_next = rr_reg;
    cdb_next = cdb_reg;
    spun_next = spun_reg;
    go = 1'b0;
    wr_ok = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_next = 1'b1;
      wd_next = s_axi_wdata;
      ws_next = s_axi_wstrb;
    end
    wa = 12'(awa_next);
    if (aw_next && w_next && !bv_reg) begin
      aw_next = 1'b0;
      w_next = 1'b0;
      bv_next = 1'b1;
      br_next = 2'b00;
      wr_ok = 1'b1;
      // Control: bit 0 starts a decode, bit 1 is the spindle-ready level.
      if (wa == `STCD_REG_CTRL) begin
        go = wd_next[0] && ws_next[0];
        if (ws_next[0]) begin
          spun_next = wd_next[1];
        end
      end else if (wa == `STCD_REG_CDB0) begin
        cdb_next[31:0] = merge(cdb_reg[31:0], wd_next, ws_next);
      end else if (wa == `STCD_REG_CDB1) begin
        cdb_next[63:32] = merge(cdb_reg[63:32], wd_next, ws_next);
      end else if (wa == `STCD_REG_CDB2) begin
        cdb_next[95:64] = merge(cdb_reg[95:64], wd_next, ws_next);
      end else if (wa == `STCD_REG_PARAM) begin
        cdb_next[127:96] = merge(cdb_reg[127:96], wd_next, ws_next); // [RQ16]
      end else begin
        br_next = 2'b10;
      end
    end else if (bv_reg && s_axi_bready) begin
      bv_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rv_next = 1'b1;
      rr_next = 2'b00;
      if (ra == `STCD_REG_CTRL) begin
        rd_next = {30'h0000_0000, spun_reg, 1'b0};
      end else if (ra == `STCD_REG_STATUS) begin
        rd_next = {16'h0000, 4'h0, sns_reg, 2'h0, chain_reg, done_reg, fsm_reg == STCD_FSM_DONE, st_reg};
      end else if (ra == `STCD_REG_RESULT) begin
        rd_next = {xfer_reg, 4'h0, msg_reg, vpd_reg, def_reg, ilv_reg, 8'h00};
      end else if (ra == `STCD_REG_CDB0) begin
        rd_next = cdb_reg[31:0];
      end else if (ra == `STCD_REG_CDB1) begin
        rd_next = cdb_reg[63:32];
      end else if (ra == `STCD_REG_CDB2) begin
        rd_next = cdb_reg[95:64];
      end else if (ra == `STCD_REG_PARAM) begin
        rd_next = cdb_reg[127:96];
      end else if (ra == `STCD_REG_MODE) begin
        rd_next = {7'h00, wp_reg, pc_reg, pg_reg, blk_reg}; // [RQ9]
      end else begin
        rd_next = 32'h0000_0000;
        rr_next = 2'b10;
      end
    end else if (rv_reg && s_axi_rready) begin
      rv_next = 1'b0;
    end
  end
  always_comb begin
    fsm_next = fsm_reg;
    st_next = st_reg;
    msg_next = msg_reg;
    sns_next = sns_reg;
    wp_next = wp_reg;
    def_next = def_reg;
    blk_next = blk_reg;
    xfer_next = xfer_reg;
    ilv_next = ilv_reg;
    pc_next = pc_reg;
    pg_next = pg_reg;
    chain_next = chain_reg;
    done_next = done_reg;
    vpd_next = vpd_reg;
    // Mode select parameter word: media type in byte 0, density in byte 1, block length above.
    case (fsm_reg)
      STCD_FSM_IDLE: begin
        if (go) begin
          fsm_next = STCD_FSM_CHECK;
          done_next = 1'b0;
        end
      end
      STCD_FSM_CHECK: begin
        fsm_next = STCD_FSM_DONE;
        done_next = 1'b1;
        st_next = STCD_ST_CHECK; // [RQ23]
        msg_next = STCD_MSG_COMPLETE;
        xfer_next = 8'h00;
        vpd_next = 1'b0;
        if (!c.known) begin
          sns_next = `STCD_SNS_OPCODE; // [RQ23]
        end else if (c.lun_bad) begin
          sns_next = `STCD_SNS_LUN; // [RQ1]
        end else if (c.field_bad || (c.is_msel && (cdb_reg[103:96] != 8'h00 || cdb_reg[111:104] != 8'h00 ||
                     !blk_ok(cdb_reg[127:112])))) begin
          sns_next = `STCD_SNS_FIELD; // [RQ16]
        end else if (c.not_ready) begin
          sns_next = `STCD_SNS_NOTREADY; // [RQ20]
        end else if (c.wp_block) begin
          sns_next = `STCD_SNS_WPROT; // [RQ12]
        end else begin
          sns_next = `STCD_SNS_NONE;
          st_next = STCD_ST_GOOD;
          if (c.is_msel) begin
            wp_next = c.wp_bit; // [RQ9]
            blk_next = cdb_reg[127:112]; // [RQ16]
          end
          if (c.is_chgdef) begin
            def_next = (cdb_reg[30:24] == 7'h03) || (cdb_reg[30:24] == 7'h04); // [RQ10]
          end
          if (c.opcode == `STCD_OP_FORMAT) begin
            ilv_next = `STCD_INTERLEAVE; // [RQ11]
          end
          if (c.opcode == `STCD_OP_INQUIRY) begin
            xfer_next = `STCD_INQ_LEN; // [RQ14]
            vpd_next = cdb_reg[8]; // [RQ15]
          end
          if (c.opcode == `STCD_OP_MSNS6 || c.opcode == `STCD_OP_MSNS10) begin
            pc_next = c.page_ctl; // [RQ18]
            pg_next = c.page_code;
          end
          if (c.link) begin
            st_next = STCD_ST_INTER; // [RQ5] [RQ22]
            msg_next = c.flag ? STCD_MSG_LINKED_FLAG : STCD_MSG_LINKED; // [RQ7] [RQ8]
          end
        end
        chain_next = (st_next == STCD_ST_INTER); // [RQ22]
      end
      STCD_FSM_DONE: begin
        if (go) begin
          fsm_next = STCD_FSM_CHECK;
          done_next = 1'b0;
        end
      end
      default: begin
        fsm_next = STCD_FSM_IDLE;
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_reg <= 1'b0;
      awa_reg <= '0;
      w_reg <= 1'b0;
      wd_reg <= 32'h0000_0000;
      ws_reg <= 4'h0;
      bv_reg <= 1'b0;
      br_reg <= 2'b00;
      rv_reg <= 1'b0;
      rd_reg <= 32'h0000_0000;
      rr_reg <= 2'b00;
      cdb_reg <= '0;
      spun_reg <= 1'b0;
      fsm_reg <= STCD_FSM_IDLE;
      st_reg <= STCD_ST_GOOD;
      msg_reg <= STCD_MSG_COMPLETE;
      sns_reg <= `STCD_SNS_NONE;
      wp_reg <= 1'b0;
      def_reg <= 1'b0;
      blk_reg <= `STCD_BLK_DEFAULT; // [RQ19]
      xfer_reg <= 8'h00;
      ilv_reg <= `STCD_INTERLEAVE;
      pc_reg <= 2'b00;
      pg_reg <= 6'h00;
      chain_reg <= 1'b0;
      done_reg <= 1'b0;
      vpd_reg <= 1'b0;
    end else if (clk_en) begin
      aw_reg <= aw_next;
      awa_reg <= awa_next;
      w_reg <= w_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      bv_reg <= bv_next;
      br_reg <= br_next;
      rv_reg <= rv_next;
      rd_reg <= rd_next;
      rr_reg <= rr_next;
      cdb_reg <= cdb_next;
      spun_reg <= spun_next;
      fsm_reg <= fsm_next;
      st_reg <= st_next;
      msg_reg <= msg_next;
      sns_reg <= sns_next;
      wp_reg <= wp_next;
      def_reg <= def_next;
      blk_reg <= blk_next;
      xfer_reg <= xfer_next;
      ilv_reg <= ilv_next;
      pc_reg <= pc_next;
      pg_reg <= pg_next;
      chain_reg <= chain_next;
      done_reg <= done_next;
      vpd_reg <= vpd_next;
    end
  end
endmodule
`default_nettype wire

/* File: sim/stcd_checker.sv */
// Concurrent checks on the register port of the command decoder.
`include "stcd_cfg.svh"
`default_nettype none
module stcd_checker #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [ADDR_W-1:0] ra_reg;
  logic [ADDR_W-1:0] ra_next;
  // Remembers the address of the read under way.
  always_comb begin
    ra_next = ra_reg;
    if (!aresetn) begin
      ra_next = '0;
    end else if (s_axi_arvalid && s_axi_arready && clk_en) begin
      ra_next = s_axi_araddr;
    end
  end
  always_ff @(posedge aclk) begin
    ra_reg <= ra_next;
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped early");
  a_w_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en
    |=> s_axi_bvalid) else $error("write response late");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
    else $error("read response late");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  a_one_interleave: assert property (s_axi_rvalid && ra_reg == `STCD_REG_RESULT |-> s_axi_rdata[15:8] == 8'h01)
    else $error("interleave not one");
  a_check_sense: assert property (s_axi_rvalid && ra_reg == `STCD_REG_STATUS && s_axi_rdata[2:0] == 3'h1
    |-> s_axi_rdata[11:8] != 4'h0) else $error("check status without sense");
  a_good_sense: assert property (s_axi_rvalid && ra_reg == `STCD_REG_STATUS && s_axi_rdata[2:0] == 3'h0
    |-> s_axi_rdata[11:8] == 4'h0) else $error("good status with sense");
  a_blk_len: assert property (s_axi_rvalid && ra_reg == `STCD_REG_MODE
    |-> s_axi_rdata[15:0] inside {16'h0200, 16'h0400, 16'h0800, 16'h1000}) else $error("bad block length");
  a_unmapped: assert property (s_axi_rvalid && ra_reg > 12'h020 |-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule
bind stcd_top stcd_checker #(.ADDR_W(ADDR_W)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
`default_nettype wire

/* File: sim/stcd_initiator.sv */
// Initiator model: builds command blocks and issues register cycles.
`default_nettype none
module stcd_initiator (
  input wire logic aclk,
  output logic [11:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [11:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'hF;
  end
  // Six-byte block; every byte not given stays zero.
  function automatic logic [95:0] cdb6(input logic [7:0] op, b1, b2, b4, ctl);
    return {48'h0, ctl, b4, 8'h00, b2, b1, op};
  endfunction
  // Ten-byte block with the control byte last.
  function automatic logic [95:0] cdb10(input logic [7:0] op, ctl);
    return {16'h0, ctl, 64'h0, op};
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] b, output logic ok);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    b = bresp;
    ok = (n < 64);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r, output logic ok);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    ok = (n < 64);
    rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench for the command decoder.
`include "stcd_cfg.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, st, res, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rr, bw;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, ok;
  logic [7:0] pg [7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h09, 8'h0A};
  int err_total = 0;
  int n_compared = 0;
  int i;
  always #2.5 aclk = ~aclk;
  stcd_top u_dut (
    .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  stcd_initiator u_init (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic hang(input logic good);
    if (!good) begin
      err_total++;
      $display("ERROR t=%0t wait ran out", $time);
      results();
    end
  endtask
  task automatic chk(input logic [31:0] seen, exp, input string m);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t %s: got %h want %h", $time, m, seen, exp);
    end
  endtask
  task automatic w(input logic [11:0] a, input logic [31:0] d);
    u_init.wr(a, d, bw, ok);
    hang(ok);
  endtask
  task automatic r(input logic [11:0] a);
    u_init.rd(a, v, rr, ok);
    hang(ok);
  endtask
  // Loads a block, starts it and waits for completion.
  task automatic go(input logic [95:0] c, input logic sp);
    int k;
    w(`STCD_REG_CDB0, c[31:0]);
    w(`STCD_REG_CDB1, c[63:32]);
    w(`STCD_REG_CDB2, c[95:64]);
    w(`STCD_REG_CTRL, {30'h0, sp, 1'b1});
    for (k = 0; k < 20; k++) begin
      r(`STCD_REG_STATUS);
      if (|v[4:3]) break;
    end
    hang(|v[4:3] === 1'b1);
    st = v & 32'hF27;
    r(`STCD_REG_RESULT);
    res = v;
  endtask
  task automatic tc(input logic [7:0] op, b1, b2, b4, ctl, input logic sp, input logic [11:0] e, input string m);
    go(u_init.cdb6(op, b1, b2, b4, ctl), sp);
    chk(st, {20'h0, e}, m);
    $display("test %s done", m);
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    r(`STCD_REG_MODE);
    chk(v & 32'h0100FFFF, 32'h00000200, "mode reset");
    $display("test mode reset done");
    tc(8'h12, 8'hA0, 8'h00, 8'h24, 8'h00, 1'b0, 12'h000, "inquiry lun5");
    chk(res & 32'hFF0C0000, 32'h24000000, "inquiry length");
    tc(8'h12, 8'h00, 8'h00, 8'h24, 8'h04, 1'b1, 12'h301, "reserved ctl");
    tc(8'h12, 8'h00, 8'h00, 8'h24, 8'h80, 1'b1, 12'h301, "vendor ctl");
    tc(8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 12'h101, "bad opcode");
    tc(8'h08, 8'h20, 8'h00, 8'h01, 8'h00, 1'b1, 12'h201, "read lun1");
    tc(8'h08, 8'h00, 8'h00, 8'h01, 8'h00, 1'b0, 12'h401, "read unspun");
    tc(8'h08, 8'h00, 8'h00, 8'h01, 8'h00, 1'b1, 12'h000, "read6");
    chk(res & 32'h000C0000, 32'h0, "plain message");
    go(u_init.cdb10(8'h28, 8'h00), 1'b1);
    chk(st, 32'h000, "read10");
    $display("test read10 done");
    tc(8'h08, 8'h00, 8'h00, 8'h01, 8'h01, 1'b1, 12'h022, "linked");
    chk(res & 32'h000C0000, 32'h00040000, "linked message");
    tc(8'h08, 8'h00, 8'h00, 8'h01, 8'h03, 1'b1, 12'h022, "linked flag");
    chk(res & 32'h000C0000, 32'h00080000, "flag message");
    tc(8'h08, 8'h00, 8'h00, 8'h01, 8'h02, 1'b1, 12'h301, "flag no link");
    tc(8'h04, 8'h00, 8'h00, 8'h05, 8'h00, 1'b1, 12'h000, "format");
    chk(res & 32'h0000FF00, 32'h00000100, "interleave");
    tc(8'h04, 8'h00, 8'h00, 8'h05, 8'h00, 1'b0, 12'h401, "format unspun");
    tc(8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 12'h000, "chgdef");
    tc(8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 12'h401, "chgdef unspun");
    tc(8'h15, 8'h00, 8'h00, 8'h0C, 8'h00, 1'b1, 12'h301, "msel zero len");
    tc(8'h55, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 12'h301, "msel10 zero len");
    w(`STCD_REG_PARAM, 32'h0400_0000);
    chk({30'h0, bw}, 32'h0, "param write");
    tc(8'h15, 8'h00, 8'h00, 8'h0C, 8'h80, 1'b1, 12'h000, "msel protect");
    r(`STCD_REG_MODE);
    chk(v & 32'h0100FFFF, 32'h01000400, "mode protect");
    tc(8'h04, 8'h00, 8'h00, 8'h05, 8'h00, 1'b1, 12'h501, "format protected");
    tc(8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 12'h501, "chgdef protected");
    tc(8'h08, 8'h00, 8'h00, 8'h01, 8'h00, 1'b1, 12'h000, "read protected");
    tc(8'h15, 8'h00, 8'h00, 8'h0C, 8'h00, 1'b1, 12'h000, "msel unprotect");
    go({64'h0, 32'h0300_0040}, 1'b1);
    chk(st, 32'h000, "chgdef scsi2");
    chk(res & 32'h00010000, 32'h00010000, "definition");
    $display("test chgdef scsi2 done");
    w(`STCD_REG_PARAM, 32'h0400_0001);
    tc(8'h15, 8'h00, 8'h00, 8'h0C, 8'h00, 1'b1, 12'h301, "msel media type");
    tc(8'h12, 8'h01, 8'h00, 8'h24, 8'h00, 1'b1, 12'h000, "inquiry vpd");
    chk(res & 32'hFF020000, 32'h24020000, "vpd flag");
    tc(8'h3C, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 12'h000, "read buffer");
    for (i = 0; i < 7; i++) begin
      tc(8'h1A, 8'h00, {i[1:0], pg[i][5:0]}, 8'h00, 8'h00, 1'b1, 12'h000, "sense page");
      r(`STCD_REG_MODE);
      chk(v & 32'h00FF0000, {8'h00, i[1:0], pg[i][5:0], 16'h0}, "page fields");
    end
    tc(8'h5A, 8'h00, 8'hC1, 8'h00, 8'h00, 1'b1, 12'h000, "sense10 saved");
    tc(8'h1A, 8'h00, 8'h05, 8'h00, 8'h00, 1'b1, 12'h301, "sense bad page");
    w(12'h100, 32'h0000_0000);
    chk({30'h0, bw}, 32'h2, "unmapped write");
    r(12'h100);
    chk({rr, v[29:0]}, 32'h80000000, "unmapped read");
    $display("test unmapped done");
    results();
  end
endmodule
`default_nettype wire
